// *** src/log_mem.sv ***
// Small word memory for lifetime log data with one write and one registered read port.
// Assumes the caller holds the read address one cycle before using the read data.
`timescale 1ns/10ps
module log_mem (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [pack_sched_pkg::LOG_AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [pack_sched_pkg::LOG_AW-1:0] raddr,
  output logic [15:0] rdata
);
  import pack_sched_pkg::*;
  // Both copies start blank, like an erased store, so the first sweep compares known words.
  logic [15:0] mem [0:(1<<LOG_AW)-1] = '{default: 16'h0000};

  // Writes and the registered read both freeze while the clock enable is low.
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // log_mem

// *** src/pack_manager_mode_scheduler.sv ***
// Power-mode scheduler, host bus-off monitor and lifetime log committer.
// Assumes all pin inputs are synchronous to sys_clk and a one-cycle register port.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module pack_manager_mode_scheduler #(
  parameter int MS_CYC = pack_sched_pkg::MS_CYCLES,
  parameter int FAST_S = pack_sched_pkg::LOG_FAST_S,
  parameter int FULL_S = pack_sched_pkg::LOG_FULL_S
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic host_bus_clock_pin,
  input wire logic host_bus_data_pin,
  input wire logic current_flow,
  input wire logic permanent_failure,
  input wire logic [15:0] cell_raw,
  input wire logic [6:0] capacity_pct,
  output logic [15:0] rdata,
  output pack_sched_pkg::mode_e mode,
  output logic meas_cycle,
  output logic low_power,
  output logic cell_refresh,
  output logic [15:0] cell_volt,
  output logic offset_cal,
  output logic bus_off,
  output logic bus_ready,
  output logic host_link_enable,
  output logic smbus_master_en,
  output logic smbus_pec_en,
  output logic [pack_sched_pkg::SEG_MAX-1:0] display_seg,
  output logic [pack_sched_pkg::TEMP_SRC-1:0] cell_temp_sel,
  output logic [pack_sched_pkg::TEMP_SRC-1:0] fet_temp_sel,
  output logic [pack_sched_pkg::KEY_BITS-1:0] key_to_engine,
  output logic irq
);
  import pack_sched_pkg::*;

  logic [13:0] ms_cnt;
  logic ms_tick;
  logic [9:0] sec_ms;
  logic sec_tick;
  logic [10:0] low_ms;
  logic both_low;
  logic bus_off_set;
  logic bus_off_clr;
  logic [15:0] cyc_ms;
  logic [15:0] period_ms;
  logic next_meas;
  logic active;
  logic [15:0] fast_s;
  logic [15:0] full_s;
  logic start_full;
  logic start_fast;
  sweep_e sweep;
  logic [LOG_AW-1:0] sweep_idx;
  logic [LOG_AW-1:0] log_index;
  logic [15:0] work_rdata;
  logic [15:0] nv_rdata;
  logic nv_we;
  logic commit_done;
  logic [15:0] commits;
  logic [15:0] sleep_int;
  logic [IRQ_W-1:0] int_status;
  logic [IRQ_W-1:0] int_mask;
  logic [IRQ_W-1:0] int_set;
  logic [TEMP_SRC-1:0] temp_en;
  logic [TEMP_SRC-1:0] temp_fet;
  logic [2:0] disp_nseg;
  logic [7:0] pf_code;
  logic [15:0] cal_gain;
  logic [15:0] cal_offset;
  logic [3:0] key_cnt;
  logic shut_req;
  logic sleep_req;
  logic wake;
  logic [31:0] cell_prod;
  logic [SEG_MAX-1:0] next_display;

  // Millisecond and second ticks derived from the system clock.
  assign ms_tick = ce && (ms_cnt == 14'(MS_CYC - 1));
  assign sec_tick = ms_tick && (sec_ms == 10'(CELL_REFRESH_MS - 1));
  assign active = (mode == MODE_NORMAL) || (mode == MODE_SLEEP);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt <= 14'h0000;
      sec_ms <= 10'h000;
    end else if (ce) begin
      ms_cnt <= ms_tick ? 14'h0000 : ms_cnt + 14'h0001;
      if (ms_tick) begin
        sec_ms <= sec_tick ? 10'h000 : sec_ms + 10'h001;
      end
    end
  end

  // Bus-off watch: count milliseconds with both lines low, clear on any high line.
  assign both_low = !host_bus_clock_pin && !host_bus_data_pin;
  assign bus_off_set = ms_tick && both_low && !bus_off &&
                       (low_ms == 11'(BUS_OFF_MS - 1)); // [RULE4]
  assign bus_off_clr = ce && bus_off && !both_low; // [RULE5]

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_ms <= 11'h000;
      bus_off <= 1'b0;
    end else if (ce) begin
      if (!both_low) begin
        low_ms <= 11'h000;
      end else if (ms_tick && (low_ms != 11'(BUS_OFF_MS - 1))) begin
        low_ms <= low_ms + 11'h001;
      end
      if (bus_off_set) begin
        bus_off <= 1'b1; // [RULE4]
      end else if (bus_off_clr) begin
        bus_off <= 1'b0; // [RULE5]
      end
    end
  end

  AST_BUS_OFF_SET: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE4]
    bus_off_set |=> bus_off) else $error("bus-off not declared after two seconds low");
  AST_BUS_OFF_END: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE5]
    $fell(bus_off) |-> $past(host_bus_clock_pin || host_bus_data_pin))
    else $error("bus-off ended while both lines stayed low");

  // Power-mode state machine.
  assign shut_req = wr && (addr == REG_CTRL) && wdata[CTRL_SHUTDOWN];
  assign sleep_req = wr && (addr == REG_CTRL) && wdata[CTRL_SLEEP];
  assign wake = (mode == MODE_SLEEP) && (current_flow || permanent_failure) && !shut_req;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= MODE_NORMAL;
      offset_cal <= 1'b0;
    end else if (ce) begin
      offset_cal <= 1'b0;
      case (mode)
        MODE_NORMAL: begin
          if (shut_req) begin
            mode <= MODE_SHUTDOWN;
          end else if (bus_off_set) begin
            mode <= MODE_CAL; // [RULE15]
            offset_cal <= 1'b1;
          end else if (sleep_req) begin
            mode <= MODE_SLEEP;
          end
        end
        MODE_CAL: begin
          mode <= shut_req ? MODE_SHUTDOWN : MODE_SLEEP; // [RULE15]
        end
        MODE_SLEEP: begin
          if (shut_req) begin
            mode <= MODE_SHUTDOWN;
          end else if (wake) begin
            mode <= MODE_NORMAL; // [RULE9]
          end
        end
        default: begin
          mode <= MODE_SHUTDOWN; // [RULE10]
        end
      endcase
    end
  end

  AST_CAL_THEN_SLEEP: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE15]
    offset_cal && ce && !shut_req |=> mode == MODE_SLEEP)
    else $error("offset calibration not followed by sleep");
  AST_WAKE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE9]
    ce && wake |=> mode == MODE_NORMAL) else $error("sleep not left on wake event");

  // Work-cycle scheduler: 250 ms in normal mode, the programmed interval in sleep.
  assign period_ms = (mode == MODE_SLEEP) ? sleep_int : 16'(NORMAL_INTERVAL_MS); // [RULE7] [RULE8]
  assign next_meas = ms_tick && active &&
                     ((period_ms == 16'h0000) || (cyc_ms >= period_ms - 16'h0001));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_ms <= 16'h0000;
      meas_cycle <= 1'b0;
      low_power <= 1'b1;
    end else if (ce) begin
      if (!active || next_meas || wake) begin // Wake restarts the interval count.
        cyc_ms <= 16'h0000;
      end else if (ms_tick) begin
        cyc_ms <= cyc_ms + 16'h0001;
      end
      meas_cycle <= next_meas; // [RULE7] [RULE8]
      low_power <= !next_meas; // [RULE7] [RULE8]
    end
  end

  AST_LOW_POWER: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE7]
    meas_cycle == !low_power) else $error("reduced power not held between cycles");
  AST_NORMAL_PERIOD: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE7]
    mode == MODE_NORMAL |-> cyc_ms < 16'(NORMAL_INTERVAL_MS))
    else $error("normal cycle longer than 250 ms");
  AST_SHUT_QUIET: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE10]
    ce && mode == MODE_SHUTDOWN |=> !meas_cycle && !cell_refresh && !host_link_enable)
    else $error("activity during shutdown");

  // Cell voltage refresh with gain and offset calibration once per second.
  assign cell_prod = cell_raw * cal_gain;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_refresh <= 1'b0;
      cell_volt <= 16'h0000;
    end else if (ce) begin
      cell_refresh <= sec_tick && active; // [RULE3]
      if (sec_tick && active) begin
        cell_volt <= 16'(cell_prod >> CAL_SHIFT) + cal_offset; // [RULE3]
      end
    end
  end

  // Link readiness and link enable, both withdrawn in shutdown.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ready <= 1'b0;
      host_link_enable <= 1'b0;
    end else if (ce) begin
      bus_ready <= !bus_off && (mode != MODE_SHUTDOWN); // [RULE6]
      host_link_enable <= mode != MODE_SHUTDOWN; // [RULE10]
    end
  end

  AST_RESUME: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
    $fell(bus_off) && ce && mode != MODE_SHUTDOWN |=> bus_ready)
    else $error("link not ready after bus-off cleared");

  // Hour timers that start the log sweeps.
  assign start_full = sec_tick && active && (full_s == 16'(FULL_S - 1));
  assign start_fast = sec_tick && active && (fast_s == 16'(FAST_S - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_s <= 16'h0000;
      full_s <= 16'h0000;
    end else if (ce && sec_tick && active) begin
      fast_s <= start_fast ? 16'h0000 : fast_s + 16'h0001;
      full_s <= start_full ? 16'h0000 : full_s + 16'h0001;
    end
  end

  // Sweep compares working and stored words and writes only the differing ones.
  assign nv_we = ce && (sweep == SW_CMP) && (work_rdata != nv_rdata); // [RULE1] [RULE2]
  assign commit_done = ce && (sweep == SW_CMP) && (sweep_idx == LOG_LAST);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sweep <= SW_IDLE;
      sweep_idx <= '0;
      commits <= 16'h0000;
    end else if (ce) begin
      case (sweep)
        SW_IDLE: begin
          if (start_full) begin
            sweep_idx <= '0; // [RULE1]
            sweep <= SW_READ;
          end else if (start_fast) begin
            sweep_idx <= LOG_FAST_FIRST; // [RULE2]
            sweep <= SW_READ;
          end
        end
        SW_READ: begin
          sweep <= SW_CMP;
        end
        default: begin
          if (nv_we) begin
            commits <= commits + 16'h0001;
          end
          if (sweep_idx == LOG_LAST) begin
            sweep <= SW_IDLE;
          end else begin
            sweep_idx <= sweep_idx + 4'h1;
            sweep <= SW_READ;
          end
        end
      endcase
    end
  end

  AST_COMMIT_DIFF: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE1]
    ce && sweep == SW_CMP && work_rdata == nv_rdata |=> commits == $past(commits))
    else $error("unchanged log word rewritten");

  log_mem u_work (
    .sys_clk(sys_clk),
    .ce(ce),
    .we(ce && wr && (addr == REG_LOG_DATA)),
    .waddr(log_index),
    .wdata(wdata),
    .raddr(sweep_idx),
    .rdata(work_rdata)
  );

  log_mem u_store (
    .sys_clk(sys_clk),
    .ce(ce),
    .we(nv_we),
    .waddr(sweep_idx),
    .wdata(work_rdata),
    .raddr(sweep_idx),
    .rdata(nv_rdata)
  );

  // Segment display: failure code wins over the capacity bar.
  for (genvar i = 0; i < SEG_MAX; i++) begin : g_seg
    assign next_display[i] = (3'(i) < disp_nseg) &&
      ({4'h0, capacity_pct} * {8'h00, disp_nseg} > 11'(i * 100));
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      display_seg <= '0;
    end else if (ce) begin
      if (mode == MODE_SHUTDOWN) begin
        display_seg <= '0;
      end else if (permanent_failure) begin
        display_seg <= pf_code[SEG_MAX-1:0]; // [RULE11]
      end else begin
        display_seg <= next_display; // [RULE11]
      end
    end
  end

  AST_DISPLAY_FAIL: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE11]
    ce && permanent_failure && mode != MODE_SHUTDOWN |=> display_seg == $past(pf_code[4:0]))
    else $error("failure code not shown");

  // Interrupt sources; a set in the clearing cycle survives.
  assign int_set[IRQ_BUS_OFF] = bus_off_set;
  assign int_set[IRQ_BUS_ON] = bus_off_clr;
  assign int_set[IRQ_WAKE] = ce && wake;
  assign int_set[IRQ_COMMIT] = commit_done;
  assign int_set[IRQ_FAIL] = ce && permanent_failure;

  // Register writes.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_int <= SLEEP_INT_RST; // [RULE16]
      int_status <= '0;
      int_mask <= '0;
      temp_en <= '0;
      temp_fet <= '0;
      disp_nseg <= DISP_SEG_RST;
      pf_code <= 8'h00;
      cal_gain <= CAL_GAIN_RST;
      cal_offset <= 16'h0000;
      log_index <= '0;
      smbus_master_en <= 1'b0;
      smbus_pec_en <= 1'b0;
      key_to_engine <= '0;
      key_cnt <= 4'h0;
    end else if (ce) begin
      int_status <= (wr && (addr == REG_INT_STATUS)) ?
                    ((int_status & ~wdata[IRQ_W-1:0]) | int_set) : (int_status | int_set);
      if (wr) begin
        if (addr == REG_CTRL) begin
          smbus_master_en <= wdata[CTRL_MASTER]; // [RULE14]
          smbus_pec_en <= wdata[CTRL_PEC]; // [RULE14]
        end else if (addr == REG_SLEEP_INT) begin
          sleep_int <= wdata; // [RULE8]
        end else if (addr == REG_INT_MASK) begin
          int_mask <= wdata[IRQ_W-1:0];
        end else if (addr == REG_TEMP_CFG) begin
          temp_en <= wdata[TEMP_SRC-1:0]; // [RULE13]
          temp_fet <= wdata[TEMP_SRC+7:8]; // [RULE13]
        end else if (addr == REG_DISP_CFG) begin
          if ((wdata[2:0] >= 3'h3) && (wdata[2:0] <= 3'h5)) begin
            disp_nseg <= wdata[2:0]; // [RULE11]
          end
          pf_code <= wdata[15:8];
        end else if (addr == REG_CAL_GAIN) begin
          cal_gain <= wdata;
        end else if (addr == REG_CAL_OFFSET) begin
          cal_offset <= wdata;
        end else if (addr == REG_LOG_INDEX) begin
          log_index <= wdata[LOG_AW-1:0];
        end else if ((addr == REG_KEY) && (key_cnt != KEY_WORDS)) begin
          key_to_engine <= {key_to_engine[KEY_BITS-17:0], wdata}; // [RULE12]
          key_cnt <= key_cnt + 4'h1;
        end
      end
    end
  end

  // Temperature routing, interrupt line and registered read data.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_temp_sel <= '0;
      fet_temp_sel <= '0;
      irq <= 1'b0;
      rdata <= 16'h0000;
    end else if (ce) begin
      cell_temp_sel <= temp_en & ~temp_fet; // [RULE13]
      fet_temp_sel <= temp_en & temp_fet; // [RULE13]
      irq <= |(int_status & int_mask);
      rdata <= 16'h0000;
      if (rd) begin
        if (addr == REG_CTRL) begin
          rdata <= {12'h000, smbus_pec_en, smbus_master_en, 2'b00};
        end else if (addr == REG_MODE) begin
          rdata <= {12'h000, low_power, bus_off, mode};
        end else if (addr == REG_SLEEP_INT) begin
          rdata <= sleep_int;
        end else if (addr == REG_INT_STATUS) begin
          rdata <= {11'h000, int_status};
        end else if (addr == REG_INT_MASK) begin
          rdata <= {11'h000, int_mask};
        end else if (addr == REG_TEMP_CFG) begin
          rdata <= {3'h0, temp_fet, 3'h0, temp_en};
        end else if (addr == REG_DISP_CFG) begin
          rdata <= {pf_code, 5'h00, disp_nseg};
        end else if (addr == REG_CAL_GAIN) begin
          rdata <= cal_gain;
        end else if (addr == REG_CAL_OFFSET) begin
          rdata <= cal_offset;
        end else if (addr == REG_LOG_INDEX) begin
          rdata <= {12'h000, log_index};
        end else if (addr == REG_COMMITS) begin
          rdata <= commits;
        end else if (addr == REG_CELL_VOLT) begin
          rdata <= cell_volt;
        end
      end
    end
  end

  AST_KEY_HIDDEN: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE12]
    ce && rd && addr == REG_KEY |=> rdata == 16'h0000)
    else $error("key word visible on read");
  AST_TEMP_EXCL: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE13]
    (cell_temp_sel & fet_temp_sel) == '0) else $error("source in both temperature roles");
endmodule // pack_manager_mode_scheduler

// *** src/pack_sched_pkg.sv ***
// Constants, register map and types of the pack manager mode scheduler.
// Assumes a 10 MHz sys_clk and a 16-bit register port.
// Operation
// RULE1 - Every ten hours each lifetime log word is compared with its stored copy and written only if it differs.
// RULE2 - Every two hours the balancing, runtime and temperature-range words are committed only if they differ.
// RULE3 - Each cell voltage is refreshed once per second after gain and offset calibration.
// RULE4 - The host bus is declared off when clock and data stay low together for two seconds.
// RULE5 - Bus-off ends only when clock or data goes high, which the host must cause.
// RULE6 - After bus-off clears the link is ready again within one millisecond.
// RULE7 - Normal mode runs the work cycle every 250 ms and idles at reduced power between cycles.
// RULE8 - Sleep mode runs the work cycle at a configurable interval and idles at reduced power between.
// RULE9 - Sleep mode is left as soon as pack current or a failure is seen.
// RULE10 - Shutdown mode stops all measurement, calculation, protection and communication.
// RULE11 - The display drives three, four or five segments showing capacity or a failure code.
// RULE12 - The 163-bit authentication key is held only inside and can never be read back.
// RULE13 - Each of five temperature sources has an enable and a cell or transistor assignment.
// RULE14 - The host link offers optional bus-master transmission and optional packet error checking.
// RULE15 - Sensing both bus lines low triggers an offset calibration followed by sleep mode; the code does so only from normal mode.
// RULE16 - The sleep interval is a field loaded at power-up with a default above the normal interval.
package pack_sched_pkg;
  // Time base.
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_MS_NS = 1000000;
  localparam int MS_CYCLES = (T_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORMAL_INTERVAL_MS = 250;
  localparam int CELL_REFRESH_MS = 1000;
  localparam int BUS_OFF_MS = 2000;
  localparam int SEC_PER_HOUR = 3600;
  localparam int LOG_FAST_H = 2;
  localparam int LOG_FULL_H = 10;
  localparam int LOG_FAST_S = LOG_FAST_H * SEC_PER_HOUR;
  localparam int LOG_FULL_S = LOG_FULL_H * SEC_PER_HOUR;
  // Register indices on the 4-bit address port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_MODE = 4'h1;
  localparam logic [3:0] REG_SLEEP_INT = 4'h2;
  localparam logic [3:0] REG_INT_STATUS = 4'h3;
  localparam logic [3:0] REG_INT_MASK = 4'h4;
  localparam logic [3:0] REG_TEMP_CFG = 4'h5;
  localparam logic [3:0] REG_DISP_CFG = 4'h6;
  localparam logic [3:0] REG_CAL_GAIN = 4'h7;
  localparam logic [3:0] REG_CAL_OFFSET = 4'h8;
  localparam logic [3:0] REG_LOG_INDEX = 4'h9;
  localparam logic [3:0] REG_LOG_DATA = 4'ha;
  localparam logic [3:0] REG_COMMITS = 4'hb;
  localparam logic [3:0] REG_KEY = 4'hc;
  localparam logic [3:0] REG_CELL_VOLT = 4'hd;
  // Control bits.
  localparam int CTRL_SHUTDOWN = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_MASTER = 2;
  localparam int CTRL_PEC = 3;
  // Interrupt bits.
  localparam int IRQ_W = 5;
  localparam int IRQ_BUS_OFF = 0;
  localparam int IRQ_BUS_ON = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_COMMIT = 3;
  localparam int IRQ_FAIL = 4;
  // Reset values.
  localparam logic [15:0] SLEEP_INT_RST = 16'h1388;
  localparam logic [15:0] CAL_GAIN_RST = 16'h1000;
  localparam logic [2:0] DISP_SEG_RST = 3'h5;
  localparam int CAL_SHIFT = 12;
  // Lifetime log layout: words from LOG_FAST_FIRST upward are the two-hour group.
  localparam int LOG_AW = 4;
  localparam logic [3:0] LOG_FAST_FIRST = 4'hc;
  localparam logic [3:0] LOG_LAST = 4'hf;
  // Authentication key.
  localparam int KEY_BITS = 163;
  localparam logic [3:0] KEY_WORDS = 4'hb;
  localparam int TEMP_SRC = 5;
  localparam int SEG_MAX = 5;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_CAL, MODE_SLEEP, MODE_SHUTDOWN} mode_e;
  typedef enum logic [1:0] {SW_IDLE, SW_READ, SW_CMP} sweep_e;
endpackage

// *** tb/host_bus_model.sv ***
// Behavioural system host driving the two host bus lines.
// Assumes the bench commands it in step with sys_clk.
`timescale 1ns/10ps
module host_bus_model (
  input wire logic sys_clk,
  input wire logic hold_low,
  input wire logic release_one,
  output logic clock_pin,
  output logic data_pin
);
  // The host keeps both lines high while it is idle.
  initial begin
    clock_pin = 1'b1;
    data_pin = 1'b1;
  end
  // A hold drags both lines low; a release may raise the clock line alone.
  always @(posedge sys_clk) begin
    clock_pin <= !hold_low;
    data_pin <= !hold_low && !release_one;
  end
endmodule // host_bus_model

// *** tb/test_pack_manager_mode_scheduler.sv ***
// Self-checking bench for the pack manager mode scheduler.
// Assumes shortened timing parameters and the host bus model beside it.
`timescale 1ns/10ps
module test_pack_manager_mode_scheduler;
  import pack_sched_pkg::*;
  localparam int MS = 4;
  logic sys_clk, reset_n, wr, rd, rd_d, hold_low, release_one, scl, sda, irq;
  logic current_flow, permanent_failure, meas_cycle, low_power, cell_refresh, offset_cal;
  logic bus_off, bus_ready, host_link_enable, smbus_master_en, smbus_pec_en;
  logic [3:0] addr;
  logic [15:0] wdata, cell_raw, rdata, cell_volt, base, got, a, k;
  logic [6:0] capacity_pct;
  logic [4:0] display_seg, cell_temp_sel, fet_temp_sel, en, fet;
  logic [162:0] key_to_engine, key_exp;
  mode_e mode;
  logic [16:0] expq[$];
  integer seed = 32'h6649;
  int mismatches = 0;
  int num_checks = 0;
  int n;

  pack_manager_mode_scheduler #(.MS_CYC(MS), .FAST_S(3), .FULL_S(5)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .host_bus_clock_pin(scl), .host_bus_data_pin(sda), .current_flow(current_flow),
    .permanent_failure(permanent_failure), .cell_raw(cell_raw), .capacity_pct(capacity_pct),
    .rdata(rdata), .mode(mode), .meas_cycle(meas_cycle), .low_power(low_power),
    .cell_refresh(cell_refresh), .cell_volt(cell_volt), .offset_cal(offset_cal),
    .bus_off(bus_off), .bus_ready(bus_ready), .host_link_enable(host_link_enable),
    .smbus_master_en(smbus_master_en), .smbus_pec_en(smbus_pec_en),
    .display_seg(display_seg), .cell_temp_sel(cell_temp_sel), .fet_temp_sel(fet_temp_sel),
    .key_to_engine(key_to_engine), .irq(irq));

  host_bus_model host_u (.sys_clk(sys_clk), .hold_low(hold_low), .release_one(release_one),
    .clock_pin(scl), .data_pin(sda));

  // Free-running 10 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [162:0] g, input logic [162:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [3:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Bit 16 of a note asks only for the read data to be kept in got.
  task automatic rreg(input logic [3:0] ad, input logic [16:0] e);
    @(posedge sys_clk);
    addr <= ad;
    rd <= 1'b1;
    expq.push_back(e);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask

  task automatic logw(input logic [3:0] idx, input logic [15:0] d);
    wreg(REG_LOG_INDEX, {12'h0, idx});
    wreg(REG_LOG_DATA, d);
  endtask

  task automatic wsig(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v) begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        mismatches++;
        end_of_test();
      end
    end
  endtask

  // Leaves in n the distance in cycles between two pulses of s.
  task automatic per(ref logic s, input int lim);
    wsig(s, 1'b1, lim);
    @(negedge sys_clk);
    wsig(s, 1'b1, lim);
    n++;
  endtask

  // Clears the sweep-done bit and waits for the next log sweep.
  task automatic sweep();
    wreg(REG_INT_STATUS, 16'h0008);
    wsig(irq, 1'b0, 4);
    wsig(irq, 1'b1, 20000);
  endtask

  // Read data stand one cycle after the strobe; the oldest note is compared then.
  always @(posedge sys_clk) begin
    if (rd_d) begin
      if (expq[0][16]) got = rdata;
      else chk(rdata, expq[0][15:0]);
      void'(expq.pop_front());
    end
    rd_d <= rd;
  end

  // Main sequence.
  initial begin
    {reset_n, wr, rd, hold_low, release_one, current_flow, permanent_failure} = '0;
    {addr, wdata, capacity_pct} = '0;
    cell_raw = 16'($random(seed)) & 16'h3fff;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    capacity_pct <= 7'd100;
    a = 16'($random(seed));
    wreg(REG_INT_MASK, 16'h0008);
    logw(4'h3, a);
    logw(4'hc, a);
    rreg(REG_SLEEP_INT, 17'h01388);
    rreg(REG_CAL_GAIN, 17'h01000);
    rreg(REG_KEY, 17'h0);
    rreg(4'hf, 17'h0);
    key_exp = '0;
    for (int i = 0; i < 12; i++) begin
      k = 16'($random(seed));
      if (i < 11) key_exp = {key_exp[146:0], k};
      wreg(REG_KEY, k);
    end
    repeat (2) @(negedge sys_clk);
    chk(key_to_engine, key_exp);
    {en, fet} = 10'($random(seed));
    wreg(REG_TEMP_CFG, {3'h0, fet, 3'h0, en});
    repeat (2) @(negedge sys_clk);
    chk({cell_temp_sel, fet_temp_sel}, {en & ~fet, en & fet});
    for (int s = 3; s < 6; s++) begin
      wreg(REG_DISP_CFG, 16'(s));
      repeat (2) @(negedge sys_clk);
      chk(display_seg, (5'h1 << s) - 5'h1);
    end
    @(posedge sys_clk);
    capacity_pct <= 7'd50;
    repeat (2) @(negedge sys_clk);
    chk(display_seg, 5'h07);
    wreg(REG_DISP_CFG, 16'h1507);
    permanent_failure <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(display_seg, 5'h15);
    @(posedge sys_clk);
    permanent_failure <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(display_seg, 5'h07);
    wreg(REG_CTRL, 16'h000c);
    rreg(REG_CTRL, 17'h0000c);
    @(negedge sys_clk);
    chk({smbus_master_en, smbus_pec_en}, 2'b11);
    $display("test registers done");
    wreg(REG_CAL_GAIN, 16'h2000);
    wreg(REG_CAL_OFFSET, 16'h0011);
    per(cell_refresh, 4100);
    chk(n, 1000 * MS);
    @(negedge sys_clk);
    chk(cell_volt, 16'(cell_raw * 2 + 16'h11));
    per(meas_cycle, 1100);
    chk({n, low_power}, {250 * MS, 1'b0});
    $display("test normal cycle done");
    sweep();
    sweep();
    rreg(REG_COMMITS, 17'h10000);
    repeat (2) @(negedge sys_clk);
    base = got;
    logw(4'h3, ~a);
    logw(4'hc, ~a);
    sweep();
    rreg(REG_COMMITS, {1'b0, base + 16'h1});
    sweep();
    rreg(REG_COMMITS, {1'b0, base + 16'h1});
    sweep();
    rreg(REG_COMMITS, {1'b0, base + 16'h2});
    $display("test log commit done");
    wreg(REG_INT_STATUS, 16'h001f);
    wreg(REG_INT_MASK, 16'h0001);
    hold_low <= 1'b1;
    wsig(bus_off, 1'b1, 8100);
    chk(n >= 7990 && n <= 8010, 1'b1);
    wsig(offset_cal, 1'b1, 3);
    repeat (2) @(negedge sys_clk);
    chk({mode, irq, bus_ready}, {MODE_SLEEP, 2'b10});
    wreg(REG_INT_STATUS, 16'h0001);
    repeat (2) @(negedge sys_clk);
    chk(irq, 1'b0);
    wreg(REG_SLEEP_INT, 16'h0002);
    per(meas_cycle, 20500);
    chk(n, 2 * MS);
    @(posedge sys_clk);
    {hold_low, release_one} <= 2'b01;
    wsig(bus_off, 1'b0, 4);
    wsig(bus_ready, 1'b1, MS);
    @(posedge sys_clk);
    current_flow <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(mode, MODE_NORMAL);
    @(posedge sys_clk);
    current_flow <= 1'b0;
    wreg(REG_CTRL, 16'h0002);
    repeat (2) @(negedge sys_clk);
    chk(mode, MODE_SLEEP);
    $display("test bus off and sleep done");
    wreg(REG_CTRL, 16'h0001);
    repeat (2) @(negedge sys_clk);
    chk({mode, host_link_enable}, {MODE_SHUTDOWN, 1'b0});
    n = 0;
    repeat (1200) @(negedge sys_clk) n += meas_cycle;
    chk(n, 0);
    $display("test shutdown done");
    end_of_test();
  end
endmodule // test_pack_manager_mode_scheduler
